// file: common/plad_map.svh
// Address map constants for the processor local address decoder.
// Assumes byte addresses of 32 bits with the target picked by the top byte, except in the 00 and ff regions, which compare the whole address.
`ifndef PLAD_MAP_SVH
`define PLAD_MAP_SVH

`define PLAD_INSTR_TCM_BASE    32'h0000_0000
`define PLAD_DATA_TCM_BASE     32'h0040_0000
`define PLAD_INSTR_TCM_BYTES   32'h0000_8000
`define PLAD_DATA_TCM_BYTES    32'h0001_0000
`define PLAD_COMM_U_BASE       32'h1000_0000
`define PLAD_TIMER_U_BASE      32'h1100_0000
`define PLAD_VIC_U_BASE        32'h1f00_0000
`define PLAD_COMM_B_BASE       32'h2000_0000
`define PLAD_TIMER_B_BASE      32'h2100_0000
`define PLAD_VIC_B_BASE        32'h2f00_0000
`define PLAD_DMA_U_BASE        32'h3000_0000
`define PLAD_DMA_B_BASE        32'h4000_0000
`define PLAD_HOLE0_BASE        32'h5000_0000
`define PLAD_SDRAM_A_BASE      32'h6000_0000
`define PLAD_SDRAM_B_BASE      32'h7000_0000
`define PLAD_HOLE1_BASE        32'h8000_0000
`define PLAD_FAB_B_BASE        32'he000_0000
`define PLAD_FAB_B_LAST        32'he600_0000
`define PLAD_HOLE2_BASE        32'he700_0000
`define PLAD_FAB_U_BASE        32'hf000_0000
`define PLAD_FAB_U_LAST        32'hf600_0000
`define PLAD_HOLE3_BASE        32'hf700_0000
`define PLAD_BOOT_BASE         32'hff00_0000
`define PLAD_HI_VECT_BASE      32'hffff_0000
`define PLAD_VIC_H_BASE        32'hffff_f000
`define PLAD_REMOTE_RAM_BYTES  32'h0100_0000
`define PLAD_SYS_RAM_IDX       3'h5

`endif

// file: common/plad_pkg.sv
// Types shared by the processor local address decoder.
// Assumes the constants of plad_map.svh give the address map.
package plad_pkg;

   typedef enum logic [3:0] {
      PLAD_TGT_NONE   = 4'h0,
      PLAD_TGT_INSTR_TIGHT_MEM   = 4'h1,
      PLAD_TGT_DATA_TIGHT_MEM   = 4'h2,
      PLAD_TGT_COMM   = 4'h3,
      PLAD_TGT_TIMER  = 4'h4,
      PLAD_TGT_VIC    = 4'h5,
      PLAD_TGT_DMA    = 4'h6,
      PLAD_TGT_SDRAM  = 4'h7,
      PLAD_TGT_FABRIC = 4'h8,
      PLAD_TGT_BOOT   = 4'h9,
      PLAD_TGT_ERROR  = 4'ha
   } plad_target_t;

   typedef enum logic [1:0] {
      PLAD_INIT_CPU   = 2'h0,
      PLAD_INIT_DMA   = 2'h1,
      PLAD_INIT_NBR   = 2'h2
   } plad_init_t;

   typedef struct packed {
      logic        valid;
      logic        write;
      plad_init_t  init;
      logic [31:0] addr;
   } plad_req_t;

   typedef struct packed {
      logic         valid;
      plad_target_t target;
      logic         buffered;
      logic         on_ahb;
      logic         via_dma;
      logic [2:0]   fab_index;
      logic         write;
      logic [31:0]  addr;
   } plad_sel_t;

endpackage : plad_pkg

// file: core/plad_decoder.sv
// Address decoder for one processing subsystem: steers each access to its target.
// Assumes requests come from logic on core_clk; one registered stage of latency.
`timescale 1ns/1ns
`include "plad_map.svh"

module plad_decoder
   import plad_pkg::*;
(
   input  wire logic      core_clk,       // Processor clock.
   input  wire logic      rstn,           // Asynchronous reset, active low.
   input  wire plad_req_t req_in,         // Incoming access request.
   input  wire logic      low_vect_set,   // Software pulse selecting low vectors.
   output plad_sel_t      sel_out,        // Registered target selection.
   output logic           bus_error,      // Registered error response pulse.
   output logic           high_exception_vectors // Vector location select.
);

   ////////////////////////////////////////////////////////////////////////////
   plad_sel_t    sel_next;
   plad_sel_t    sel_reg;
   logic         err_next;
   logic         err_reg;
   logic         hiv_reg;
   logic [7:0]   top;
   logic [31:0]  off;

   assign top = req_in.addr[31:24];

   always_comb begin
      off      = req_in.addr;
      sel_next = '0;
      sel_next.valid     = req_in.valid;
      sel_next.write     = req_in.write;
      sel_next.addr      = req_in.addr;
      sel_next.target    = PLAD_TGT_ERROR;
      if (req_in.init != PLAD_INIT_CPU) begin
         // Remote initiators only ever see system RAM in the low 16 MB.
         if (top == 8'h00) begin
            sel_next.target    = PLAD_TGT_FABRIC;
            sel_next.via_dma   = 1'b1;
            sel_next.fab_index = `PLAD_SYS_RAM_IDX;
            sel_next.addr      = req_in.addr & (`PLAD_REMOTE_RAM_BYTES - 32'h1);
         end
         else begin
            sel_next.target = PLAD_TGT_ERROR;
         end
      end
      else if (top == `PLAD_INSTR_TCM_BASE >> 24) begin
         if (req_in.addr < `PLAD_INSTR_TCM_BASE + `PLAD_INSTR_TCM_BYTES)
            sel_next.target = PLAD_TGT_INSTR_TIGHT_MEM;
         else if (req_in.addr >= `PLAD_DATA_TCM_BASE &&
                  req_in.addr < `PLAD_DATA_TCM_BASE + `PLAD_DATA_TCM_BYTES)
            sel_next.target = PLAD_TGT_DATA_TIGHT_MEM;
         else
            sel_next.target = PLAD_TGT_ERROR;
         off = req_in.addr;
      end
      else begin
         sel_next.on_ahb = 1'b1;
         if (req_in.addr >= `PLAD_VIC_H_BASE) begin
            sel_next.target = PLAD_TGT_VIC;
         end
         else if (top == `PLAD_BOOT_BASE >> 24) begin
            sel_next.target = PLAD_TGT_BOOT;
         end
         else if (top == `PLAD_COMM_U_BASE >> 24 || top == `PLAD_COMM_B_BASE >> 24) begin
            sel_next.target   = PLAD_TGT_COMM;
            sel_next.buffered = top[5];
         end
         else if (top == `PLAD_TIMER_U_BASE >> 24 || top == `PLAD_TIMER_B_BASE >> 24) begin
            sel_next.target   = PLAD_TGT_TIMER;
            sel_next.buffered = top[5];
         end
         else if (top == `PLAD_VIC_U_BASE >> 24 || top == `PLAD_VIC_B_BASE >> 24) begin
            sel_next.target   = PLAD_TGT_VIC;
            sel_next.buffered = top[5];
         end
         else if (top[7:4] == 4'h3 || top[7:4] == 4'h4) begin
            sel_next.target   = PLAD_TGT_DMA;
            sel_next.buffered = (top[7:4] == 4'h4);
         end
         else if (top[7:4] == 4'h6 || top[7:4] == 4'h7) begin
            sel_next.target   = PLAD_TGT_SDRAM;
            sel_next.via_dma  = 1'b1;
            sel_next.buffered = (top[7:4] == 4'h6);
         end
         else if (req_in.addr >= `PLAD_FAB_B_BASE && req_in.addr < `PLAD_HOLE2_BASE) begin
            sel_next.target    = PLAD_TGT_FABRIC;
            sel_next.via_dma   = 1'b1;
            sel_next.buffered  = 1'b1;
            sel_next.fab_index = top[2:0];
         end
         else if (req_in.addr >= `PLAD_FAB_U_BASE && req_in.addr < `PLAD_HOLE3_BASE) begin
            sel_next.target    = PLAD_TGT_FABRIC;
            sel_next.via_dma   = 1'b1;
            sel_next.fab_index = top[2:0];
         end
         else begin
            sel_next.target = PLAD_TGT_ERROR;
            sel_next.on_ahb = 1'b0;
         end
      end
      // An error reaches no target, so no write lands anywhere.
      err_next = req_in.valid && (sel_next.target == PLAD_TGT_ERROR);
      if (sel_next.target == PLAD_TGT_ERROR) begin
         sel_next.valid   = 1'b0;
         sel_next.on_ahb  = 1'b0;
         sel_next.via_dma = 1'b0;
      end
      if (off != req_in.addr)
         sel_next.addr = off;
   end

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         sel_reg <= '0;
         err_reg <= 1'b0;
      end
      else begin
         sel_reg <= sel_next;
         err_reg <= err_next;
      end
   end

   // High vectors hold from reset until software asks for low ones.
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn)
         hiv_reg <= 1'b1;
      else if (low_vect_set)
         hiv_reg <= 1'b0;
   end

   assign sel_out                = sel_reg;
   assign bus_error              = err_reg;
   assign high_exception_vectors = hiv_reg;

endmodule : plad_decoder

// file: test/plad_decoder_props.sv
// Port checker for the address decoder, bound at the foot.
// Assumes the decoder top module and the shared package.
`timescale 1ns/1ns
module plad_decoder_props
   import plad_pkg::*;
(
   input wire logic      core_clk, // Clock.
   input wire logic      rstn, // Reset.
   input wire plad_req_t req_in, // Request.
   input wire logic      low_vect_set, // Low vectors.
   input wire plad_sel_t sel_out, // Target.
   input wire logic      bus_error, // Error.
   input wire logic      high_exception_vectors // Vectors.
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rstn);
   wire logic       cpu = req_in.valid && req_in.init == PLAD_INIT_CPU;
   wire logic [7:0] top = req_in.addr[31:24];
   sequence s_err; bus_error && !sel_out.valid && !sel_out.on_ahb; endsequence
   sequence s_fab(b);
      sel_out.target == PLAD_TGT_FABRIC && sel_out.via_dma && sel_out.buffered == b;
   endsequence
   AST_HOLE: assert property (cpu && top inside {8'h50, 8'h80, 8'he7, 8'hf7}
      |=> s_err) else $error("hole not refused");
   AST_REMOTE: assert property (req_in.valid && req_in.init != PLAD_INIT_CPU
      && top != 8'h00 |=> s_err) else $error("remote not refused");
   AST_FAB_BUF: assert property (cpu && top inside {[8'he0:8'he6]} |=> s_fab(1'b1)
      && sel_out.fab_index == $past(req_in.addr[26:24])) else $error("fabric b");
   AST_FAB_UNBUF: assert property (cpu && top inside {[8'hf0:8'hf6]}
      |=> s_fab(1'b0)) else $error("fabric u");
   AST_INSTR_TIGHT_MEM: assert property (cpu && req_in.addr < 32'h8000 |=>
      sel_out.target == PLAD_TGT_INSTR_TIGHT_MEM) else $error("instr_tight_mem");
   AST_OFFSET: assert property (cpu |=> bus_error ||
      sel_out.addr == $past(req_in.addr)) else $error("offset");
   AST_AHB: assert property (sel_out.valid && $past(req_in.init) == PLAD_INIT_CPU |->
      sel_out.on_ahb != (sel_out.target inside {PLAD_TGT_INSTR_TIGHT_MEM, PLAD_TGT_DATA_TIGHT_MEM}))
      else $error("ahb");
   AST_LOWVEC: assert property (low_vect_set |=>
      !high_exception_vectors) else $error("low vectors");
endmodule : plad_decoder_props
bind plad_decoder plad_decoder_props plad_decoder_props_inst (.core_clk, .rstn, .req_in,
   .low_vect_set, .sel_out, .bus_error, .high_exception_vectors);

// file: test/plad_target_model.sv
// Far-side target model: counts selections that come with an error.
// Assumes direct hook-up to the decoder outputs.
`timescale 1ns/1ns
module plad_target_model
   import plad_pkg::*;
(
   input  wire logic      core_clk, // Clock.
   input  wire logic      rstn, // Reset.
   input  wire plad_sel_t sel_out, // Target.
   input  wire logic      bus_error, // Error.
   output logic [7:0]     stray_reg // Bad accesses.
);
   // A target acting on an erroring cycle would corrupt it, so count those.
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) stray_reg <= 8'h00;
      else stray_reg <= stray_reg + 8'(sel_out.valid && bus_error);
   end
endmodule : plad_target_model

// file: test/tb_plad_decoder.sv
// Self-checking bench for the address decoder.
// Assumes the decoder, its checker and the target model.
`timescale 1ns/1ns
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin failures++; \
   $display("Error %s expected %h seen %h", n, e, g); end end
module tb_plad_decoder;
   import plad_pkg::*;
   logic         core_clk, rstn, low_vect_set, bus_error, high_exception_vectors;
   plad_req_t    req_in;
   plad_sel_t    sel_out;
   plad_target_t t;
   logic [7:0]   stray_reg;
   logic [39:0]  r;
   int           failures, tests_run, cycles;
   // Row: initiator nibble, address, expected target.
   logic [39:0]  rows [] = '{40'h0000000001, 40'h000007ffc1, 40'h000008000a,
      40'h00040fffc2, 40'h000410000a, 40'h0100000003, 40'h01f0000005, 40'h0210000004,
      40'h02f0000005, 40'h0300000006, 40'h0400000006, 40'h050000000a, 40'h0600000007,
      40'h0700000007, 40'h080000000a, 40'h0e60000008, 40'h0e7000000a, 40'h0f00000008,
      40'h0f7000000a, 40'h0ff0000009, 40'h0fffff0005, 40'h100abcdef8, 40'h2001234568,
      40'h110000000a};
   plad_decoder plad_decoder_inst (.core_clk, .rstn, .req_in, .low_vect_set, .sel_out,
      .bus_error, .high_exception_vectors);
   plad_target_model plad_target_model_inst (.core_clk, .rstn, .sel_out, .bus_error,
      .stray_reg);
   task end_sim;
      $display("Checks %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : end_sim
   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 1000) begin
         failures++;
         end_sim();
      end
   end
   initial begin
      rstn = 1'b0;
      req_in = '0;
      low_vect_set = 1'b0;
      repeat (6) @(negedge core_clk);
      `CHK("sel", plad_sel_t'(0), sel_out)
      rstn = 1'b1;
      for (int k = 0; k <= rows.size(); k++) begin
         @(negedge core_clk);
         if (k > 0) begin
            r = rows[k - 1];
            t = plad_target_t'(r[3:0]);
            `CHK("target", t, sel_out.target)
            `CHK("err", t == PLAD_TGT_ERROR, bus_error)
            `CHK("write", !k[0], sel_out.write)
            if (t != PLAD_TGT_ERROR)
               `CHK("addr", r[37:36] == 0 ? r[35:4] : {8'h00, r[27:4]}, sel_out.addr)
            if (r[37:36] != 0 && t == PLAD_TGT_FABRIC)
               `CHK("ram", 3'h5, sel_out.fab_index)
            if (r[37:36] == 0 && t inside {[PLAD_TGT_COMM:PLAD_TGT_FABRIC]})
               `CHK("buf", r[35:32] inside {4'h2, 4'h4, 4'h6, 4'he}, sel_out.buffered)
         end
         if (k < rows.size()) req_in = {1'b1, k[0], rows[k][37:4]};
         else req_in = '0;
      end
      `CHK("stray", 8'h00, stray_reg)
      `CHK("hiv", 1'b1, high_exception_vectors)
      low_vect_set = 1'b1;
      @(negedge core_clk);
      low_vect_set = 1'b0;
      `CHK("lowv", 1'b0, high_exception_vectors)
      rstn = 1'b0;
      #1 `CHK("rst", 1'b1, high_exception_vectors)
      @(negedge core_clk);
      rstn = 1'b1;
      end_sim();
   end
endmodule : tb_plad_decoder
